// >>> fpmc_top.sv
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "fpmc_params.svh"

module fpmc_top #(
  parameter logic [`FPMC_TMR_W-1:0] HOLD_CYC = 40'(`FPMC_HOLD_CYC),
  parameter logic [`FPMC_TMR_W-1:0] IDLE_CYC = 40'(`FPMC_IDLE_CYC),
  parameter logic [`FPMC_DEB_W-1:0] DEB_CYC = 32'(`FPMC_DEB_CYC)
) (
  // Clock and reset.
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // Front-panel push buttons, high while pressed.
  input wire fpmc_pkg::fpmc_buttons_t BUTTONS_I,
  // Alarm state from the protection logic of the unit.
  input wire logic FAILURE_I,
  input wire logic HORN_ON_I,
  // APB slave.
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Lamps, mode and engine.
  output fpmc_pkg::fpmc_leds_t LEDS_O,
  output fpmc_pkg::fpmc_mode_t MODE_O,
  output logic ENGINE_RUN_O,
  // Contactor relay drives, high energises the coil.
  output logic MAINS_RELAY_O,
  output logic GEN_RELAY_O,
  // Action pulses.
  output fpmc_pkg::fpmc_events_t EVENTS_O
);

  fpmc_pkg::fpmc_mode_t mode_r;
  fpmc_pkg::fpmc_mode_t mode_nxt;
  fpmc_pkg::fpmc_buttons_t held;
  fpmc_pkg::fpmc_buttons_t press;
  fpmc_pkg::fpmc_leds_t leds_r;
  fpmc_pkg::fpmc_leds_t leds_nxt;
  fpmc_pkg::fpmc_events_t events_r;
  fpmc_pkg::fpmc_events_t events_nxt;
  logic engine_r;
  logic engine_nxt;
  logic mains_r;
  logic mains_nxt;
  logic gen_r;
  logic gen_nxt;
  logic ichk_r;
  logic arm_r;
  logic mrelay_r;
  logic grelay_r;
  logic [1:0] auto_r;
  logic [31:0] prdata_r;
  logic hold_done;
  logic idle_done;

  // Each button gets its own synchroniser and debouncer.
  genvar gi;
  generate
    for (gi = 0; gi < $bits(fpmc_pkg::fpmc_buttons_t); gi++) begin : g_btn
      fpmc_debounce #(
        .DEB_CYC(DEB_CYC)
      ) u_deb (
        .CLOCK_I(CLOCK_I),
        .RST_I(RST_I),
        .raw_i(BUTTONS_I[gi]),
        .level_o(held[gi]),
        .press_o(press[gi])
      );
    end
  endgenerate

  // Mode decode.
  wire in_off = mode_r == fpmc_pkg::MODE_OFF;
  wire in_man = mode_r == fpmc_pkg::MODE_MANUAL;
  wire in_prog = mode_r == fpmc_pkg::MODE_PROG;
  wire nxt_prog = mode_nxt == fpmc_pkg::MODE_PROG;
  wire nxt_run = (mode_nxt == fpmc_pkg::MODE_MANUAL)
                 || (mode_nxt == fpmc_pkg::MODE_AUTO)
                 || (mode_nxt == fpmc_pkg::MODE_TEST);
  wire any_held = |held;

  // The hold timer runs only from off mode, so a hold elsewhere is refused.
  // The arm flag stops a timeout from re-entering while still held.
  wire hold_run = held.indicator_check && arm_r && in_off;
  wire idle_run = in_prog && !any_held;

  fpmc_timer #(
    .LIMIT(HOLD_CYC)
  ) u_hold (
    .CLOCK_I(CLOCK_I),
    .RST_I(RST_I),
    .run_i(hold_run),
    .done_o(hold_done)
  );

  fpmc_timer #(
    .LIMIT(IDLE_CYC)
  ) u_idle (
    .CLOCK_I(CLOCK_I),
    .RST_I(RST_I),
    .run_i(idle_run),
    .done_o(idle_done)
  );

  // Mode selection; off has the highest priority among the mode buttons.
  always_comb begin
    mode_nxt = mode_r;
    if (press.off) begin
      mode_nxt = fpmc_pkg::MODE_OFF;
    end else if (press.test) begin
      mode_nxt = fpmc_pkg::MODE_TEST;
    end else if (press.auto_m) begin
      mode_nxt = fpmc_pkg::MODE_AUTO;
    end else if (press.manual) begin
      mode_nxt = fpmc_pkg::MODE_MANUAL;
    end else if (hold_done) begin
      mode_nxt = fpmc_pkg::MODE_PROG;
    end else if (idle_done) begin
      mode_nxt = fpmc_pkg::MODE_OFF;
    end
  end

  // Engine and load control follow the mode being entered, so an off press
  // stops the engine at the same edge that changes the mode.
  always_comb begin
    engine_nxt = engine_r;
    mains_nxt = mains_r;
    gen_nxt = gen_r;
    unique case (mode_nxt)
      fpmc_pkg::MODE_OFF, fpmc_pkg::MODE_PROG: begin
        engine_nxt = 1'b0;
        mains_nxt = 1'b1;
        gen_nxt = 1'b0;
      end
      fpmc_pkg::MODE_TEST: begin
        engine_nxt = 1'b1;
        mains_nxt = 1'b1;
        gen_nxt = 1'b0;
      end
      fpmc_pkg::MODE_AUTO: begin
        engine_nxt = auto_r[`FPMC_AUTO_ENG_BIT];
        gen_nxt = auto_r[`FPMC_AUTO_GEN_BIT] && engine_nxt;
        mains_nxt = !gen_nxt;
      end
      fpmc_pkg::MODE_MANUAL: begin
        if (in_man && press.start) begin
          engine_nxt = 1'b1;
        end else if (in_man && press.stop) begin
          engine_nxt = 1'b0;
        end
        if (in_man && press.to_mains) begin
          mains_nxt = 1'b1;
          gen_nxt = 1'b0;
        end else if (in_man && press.to_gen) begin
          gen_nxt = 1'b1;
          mains_nxt = 1'b0;
        end else begin
          if (in_man && press.mains_open) begin
            mains_nxt = 1'b0;
          end
          if (in_man && press.gen_open) begin
            gen_nxt = 1'b0;
          end
        end
      end
    endcase
  end

  // Lamp pattern; the check overrides everything until the button is let go
  // or programming starts, after which the normal pattern returns.
  wire ichk_nxt = held.indicator_check && !nxt_prog;
  always_comb begin
    leds_nxt.test = mode_nxt == fpmc_pkg::MODE_TEST;
    leds_nxt.off = mode_nxt == fpmc_pkg::MODE_OFF;
    leds_nxt.auto_m = mode_nxt == fpmc_pkg::MODE_AUTO;
    leds_nxt.prog = nxt_prog;
    leds_nxt.eng_run = nxt_run && engine_nxt;
    leds_nxt.eng_stop = nxt_run && !engine_nxt;
    leds_nxt.mains_on = mains_nxt;
    leds_nxt.mains_off = !mains_nxt;
    leds_nxt.gen_on = gen_nxt;
    leds_nxt.gen_off = !gen_nxt;
    if (ichk_nxt) begin
      leds_nxt = '1;
    end
  end

  // Two-meaning buttons: alarm handling and display stepping normally, editing in programming.
  always_comb begin
    events_nxt.fail_reset = press.increment && !in_prog && FAILURE_I;
    events_nxt.param_up = press.increment && in_prog;
    events_nxt.alarm_mute = press.decrement && !in_prog
                            && FAILURE_I && HORN_ON_I;
    events_nxt.param_down = press.decrement && in_prog;
    events_nxt.param_confirm = press.select && in_prog;
    events_nxt.display_step = press.select && !in_prog;
  end

  // State registers.
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      mode_r <= fpmc_pkg::MODE_OFF;
      engine_r <= 1'b0;
      mains_r <= 1'b1;
      gen_r <= 1'b0;
      arm_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      engine_r <= engine_nxt;
      mains_r <= mains_nxt;
      gen_r <= gen_nxt;
      arm_r <= (arm_r || press.indicator_check) && held.indicator_check
               && !hold_done;
    end
  end

  // Output registers; relays are driven so a dead output leaves load on mains.
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      leds_r <= `FPMC_LEDS_RST;
      events_r <= '0;
      ichk_r <= 1'b0;
      mrelay_r <= 1'b0;
      grelay_r <= 1'b0;
    end else begin
      leds_r <= leds_nxt;
      events_r <= events_nxt;
      ichk_r <= ichk_nxt;
      mrelay_r <= !mains_nxt;
      grelay_r <= gen_nxt;
    end
  end

  // APB decode; the slave never waits, so PREADY is always high.
  wire hit_status = PADDR_I == `FPMC_OFS_STATUS;
  wire hit_auto = PADDR_I == `FPMC_OFS_AUTO;
  wire hit = hit_status || hit_auto;
  wire access = PSEL_I && PENABLE_I;
  wire setup = PSEL_I && !PENABLE_I;
  wire wr_auto = access && PWRITE_I && hit_auto && PSTRB_I[0];
  wire [31:0] status_word = {
    21'h000000, HORN_ON_I, FAILURE_I, ichk_r, arm_r,
    gen_r, mains_r, engine_r, 1'b0, mode_r
  };
  wire [31:0] rd_word = hit_status ? status_word :
                        hit_auto ? {30'h00000000, auto_r} : 32'h00000000;

  // Read data is captured in the setup cycle so it is a flop at access.
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      auto_r <= `FPMC_AUTO_RST;
      prdata_r <= 32'h00000000;
    end else begin
      if (wr_auto) begin
        auto_r <= PWDATA_I[1:0];
      end
      if (setup) begin
        prdata_r <= PWRITE_I ? 32'h00000000 : rd_word;
      end
    end
  end

  assign PRDATA_O = prdata_r;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = access && !hit;
  assign LEDS_O = leds_r;
  assign MODE_O = mode_r;
  assign ENGINE_RUN_O = engine_r;
  assign MAINS_RELAY_O = mrelay_r;
  assign GEN_RELAY_O = grelay_r;
  assign EVENTS_O = events_r;

  // Checks on the design's own behaviour.
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);

  chk_test_entry: assert property (
    press.test && !press.off |=> mode_r == fpmc_pkg::MODE_TEST && LEDS_O.test)
    else $error("test press did not select test mode");

  chk_off_entry: assert property (
    press.off |=> mode_r == fpmc_pkg::MODE_OFF && !ENGINE_RUN_O && LEDS_O.off)
    else $error("off press did not stop engine in off mode");

  chk_auto_entry: assert property (
    press.auto_m && !press.off && !press.test
    |=> mode_r == fpmc_pkg::MODE_AUTO && LEDS_O.auto_m)
    else $error("auto press did not select auto mode");

  chk_mode_lamps: assert property (
    !ichk_r |-> LEDS_O.test == (mode_r == fpmc_pkg::MODE_TEST)
    && LEDS_O.off == in_off && LEDS_O.auto_m == (mode_r == fpmc_pkg::MODE_AUTO))
    else $error("mode lamp disagrees with mode");

  chk_prog_lamp: assert property (
    LEDS_O.prog == in_prog || ichk_r)
    else $error("programming lamp disagrees with mode");

  chk_lamp_check: assert property (
    ichk_r |-> LEDS_O == '1)
    else $error("indicator check did not light all lamps");

  chk_prog_entry: assert property (
    hold_done && !press.off && !press.test && !press.auto_m && !press.manual
    |=> in_prog && LEDS_O.prog)
    else $error("hold did not enter programming");

  chk_prog_refused: assert property (
    !in_off && !in_prog |=> !in_prog)
    else $error("programming entered from a mode other than off");

  chk_manual_gate: assert property (
    !$past(engine_r) && engine_r && $past(in_man) && in_man |-> $past(press.start))
    else $error("engine started in manual without start press");

  chk_gen_gate: assert property (
    in_man && !gen_r ##1 in_man && gen_r |-> $past(press.to_gen))
    else $error("generator connected in manual without button");

  chk_relay_drive: assert property (
    MAINS_RELAY_O == !mains_r && GEN_RELAY_O == gen_r && !(mains_r && gen_r))
    else $error("relay drive disagrees with contactor state");

  chk_idle_exit: assert property (
    idle_done && !(|press) |=> in_off)
    else $error("inactivity did not leave programming");

  cov_prog: cover property (in_off ##1 in_prog);
  cov_manual_start: cover property (in_man && press.start ##1 engine_r);
  cov_idle: cover property (in_prog && idle_done ##1 in_off);

endmodule // fpmc_top

// >>> fpmc_params.svh
`ifndef FPMC_PARAMS_SVH
`define FPMC_PARAMS_SVH

// System clock rate in hertz.
`define FPMC_CLK_HZ 200000000

// Hold time into programming, in seconds.
`define FPMC_HOLD_S 5
// Inactivity time that ends programming, in seconds.
`define FPMC_IDLE_S 120
// Settling time of a push button, in milliseconds.
`define FPMC_DEB_MS 10

// Cycle counts derived from the times above.
`define FPMC_HOLD_CYC (64'd`FPMC_HOLD_S * 64'd`FPMC_CLK_HZ)
`define FPMC_IDLE_CYC (64'd`FPMC_IDLE_S * 64'd`FPMC_CLK_HZ)
`define FPMC_DEB_CYC ((64'd`FPMC_DEB_MS * 64'd`FPMC_CLK_HZ) / 64'd1000)

// Counter widths for the long timers and the debouncer.
`define FPMC_TMR_W 40
`define FPMC_DEB_W 32

// Register byte offsets.
`define FPMC_OFS_STATUS 12'h000
`define FPMC_OFS_AUTO 12'h004

// Field positions of the automatic command register.
`define FPMC_AUTO_ENG_BIT 0
`define FPMC_AUTO_GEN_BIT 1
// Reset value of the automatic command register.
`define FPMC_AUTO_RST 2'h0

// Lamp pattern while reset holds: off mode with the load on mains, so the
// lamps already agree with the mode at the first edge after release.
`define FPMC_LEDS_RST 10'h051

`endif

// >>> fpmc_pkg.sv
package fpmc_pkg;

  // Operating modes of the panel.
  typedef enum logic [2:0] {
    MODE_OFF,
    MODE_MANUAL,
    MODE_AUTO,
    MODE_TEST,
    MODE_PROG
  } fpmc_mode_t;

  // One bit per front-panel push button.
  typedef struct packed {
    logic test;
    logic indicator_check;
    logic increment;
    logic start;
    logic to_mains;
    logic to_gen;
    logic off;
    logic auto_m;
    logic decrement;
    logic stop;
    logic mains_open;
    logic gen_open;
    logic select;
    logic manual;
  } fpmc_buttons_t;

  // Panel indicator lamps, one bit per lamp, high is lit.
  typedef struct packed {
    logic test;
    logic prog;
    logic eng_run;
    logic mains_on;
    logic gen_on;
    logic off;
    logic auto_m;
    logic eng_stop;
    logic mains_off;
    logic gen_off;
  } fpmc_leds_t;

  // One-cycle action pulses towards the rest of the unit.
  typedef struct packed {
    logic fail_reset;
    logic alarm_mute;
    logic param_up;
    logic param_down;
    logic param_confirm;
    logic display_step;
  } fpmc_events_t;

endpackage

// >>> fpmc_debounce.sv
`timescale 1ns/10ps
`include "fpmc_params.svh"

module fpmc_debounce #(
  parameter logic [`FPMC_DEB_W-1:0] DEB_CYC = 32'd1
) (
  // Clock and reset.
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // Raw button pin.
  input wire logic raw_i,
  // Clean level and press pulse.
  output logic level_o,
  output logic press_o
);

  logic sync1_r;
  logic sync2_r;
  logic stable_r;
  logic press_r;
  logic [`FPMC_DEB_W-1:0] cnt_r;
  wire differ = sync2_r != stable_r;
  wire settled = differ && (cnt_r >= DEB_CYC - 32'd1);

  // Two flops bring the pin into the clock domain before anything reads it.
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= raw_i;
      sync2_r <= sync1_r;
    end
  end

  // A new level is accepted only after it has stood for the full settling
  // time, and a press gives exactly one pulse, not one per clock held.
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      cnt_r <= '0;
      stable_r <= 1'b0;
      press_r <= 1'b0;
    end else begin
      cnt_r <= (differ && !settled) ? cnt_r + 32'd1 : '0;
      if (settled) begin
        stable_r <= sync2_r;
      end
      press_r <= settled && sync2_r;
    end
  end

  assign level_o = stable_r;
  assign press_o = press_r;

endmodule // fpmc_debounce

// >>> fpmc_timer.sv
`timescale 1ns/10ps
`include "fpmc_params.svh"

module fpmc_timer #(
  parameter logic [`FPMC_TMR_W-1:0] LIMIT = 40'd1
) (
  // Clock and reset.
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // Count while high, clear while low.
  input wire logic run_i,
  // High once the count has reached the limit.
  output logic done_o
);

  logic [`FPMC_TMR_W-1:0] cnt_r;

  // The count saturates so that done stays high until run drops.
  always_ff @(posedge CLOCK_I) begin
    if (RST_I || !run_i) begin
      cnt_r <= '0;
    end else if (cnt_r != LIMIT) begin
      cnt_r <= cnt_r + 40'd1;
    end
  end

  assign done_o = run_i && (cnt_r == LIMIT);

endmodule // fpmc_timer

// >>> fpmc_panel_model.sv
`timescale 1ns/10ps

// Operator side of the panel: fingers on the buttons, eyes on the lamps.
module fpmc_panel_model (
  // Clock.
  input wire logic CLOCK_I,
  // Lamps as the operator sees them.
  input wire fpmc_pkg::fpmc_leds_t leds_i,
  // Buttons, high while pressed, and a summary of the lamps.
  output fpmc_pkg::fpmc_buttons_t buttons_o,
  output logic all_lit_o
);
  logic [13:0] held_r = 14'h0000;

  // A finger moves only just after an edge, so no press races the clock.
  assign buttons_o = fpmc_pkg::fpmc_buttons_t'(held_r);
  assign all_lit_o = &leds_i;

  // Presses one button for a number of cycles, then lets it go.
  task automatic hold(input int idx, input int n);
    @(posedge CLOCK_I);
    held_r[idx] <= 1'b1;
    repeat (n) @(posedge CLOCK_I);
    held_r[idx] <= 1'b0;
  endtask
endmodule // fpmc_panel_model

// >>> testbench.sv
`timescale 1ns/10ps

module testbench;
  localparam int B_TEST = 13;
  localparam int B_CHK = 12;
  localparam int B_INC = 11;
  localparam int B_START = 10;
  localparam int B_TOM = 9;
  localparam int B_TOG = 8;
  localparam int B_OFF = 7;
  localparam int B_AUTO = 6;
  localparam int B_DEC = 5;
  localparam int B_STOP = 4;
  localparam int B_MOPEN = 3;
  localparam int B_GOPEN = 2;
  localparam int B_SEL = 1;
  localparam int B_MAN = 0;

  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic failure = 1'b0;
  logic horn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rd;
  logic err;
  logic all_lit;
  logic ev_clr = 1'b0;
  int n_step = 0;
  int n_fail = 0;
  int checked = 0;
  fpmc_pkg::fpmc_buttons_t buttons;
  fpmc_pkg::fpmc_leds_t leds;
  fpmc_pkg::fpmc_mode_t mode;
  fpmc_pkg::fpmc_events_t events;
  fpmc_pkg::fpmc_events_t ev_acc = '0;
  logic engine;
  logic mains_relay;
  logic gen_relay;

  // Short counts keep the long timers within a brief run.
  fpmc_top #(.HOLD_CYC(40'd50), .IDLE_CYC(40'd100), .DEB_CYC(32'd4)) fpmc_top_i (
    .CLOCK_I(clock_i), .RST_I(rst_i), .BUTTONS_I(buttons),
    .FAILURE_I(failure), .HORN_ON_I(horn),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hF),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .LEDS_O(leds), .MODE_O(mode), .ENGINE_RUN_O(engine),
    .MAINS_RELAY_O(mains_relay), .GEN_RELAY_O(gen_relay),
    .EVENTS_O(events));

  fpmc_panel_model fpmc_panel_model_i (
    .CLOCK_I(clock_i), .leds_i(leds), .buttons_o(buttons),
    .all_lit_o(all_lit));

  // The clock runs at 200 MHz.
  initial begin
    forever #2.5 clock_i = ~clock_i;
  end

  // Event pulses last one cycle, so they are gathered until cleared.
  always @(posedge clock_i) begin
    ev_acc <= ev_clr ? '0 : (ev_acc | events);
    n_step <= ev_clr ? 0 : n_step + int'(events.display_step);
  end

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock_i);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready.
    do begin
      @(posedge clock_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // A press, then time for debounce on release and the state to settle.
  task automatic push(input int idx, input int n);
    fpmc_panel_model_i.hold(idx, n);
    repeat (10) @(posedge clock_i);
  endtask

  task automatic clr_ev();
    @(posedge clock_i);
    ev_clr <= 1'b1;
    @(posedge clock_i);
    ev_clr <= 1'b0;
  endtask

  task automatic end_sim();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the roughly 800 cycles needed.
  initial begin
    repeat (20000) @(posedge clock_i);
    n_fail++;
    end_sim();
  end

  initial begin
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    check("leds", leds, 32'h00000051);
    check("relays", {mains_relay, gen_relay}, 32'h00000000);
    apb(1'b0, 12'h000, 32'h00000000);
    check("status", rd, 32'h00000020);
    apb(1'b1, 12'h004, 32'h00000003);
    apb(1'b0, 12'h004, 32'h00000000);
    check("auto_reg", rd, 32'h00000003);
    apb(1'b1, 12'h008, 32'h00000001);
    check("slverr", err, 32'h00000001);
    // Manual-only buttons must do nothing while off.
    push(B_START, 12);
    push(B_TOG, 12);
    check("eng_off", engine, 32'h00000000);
    check("gen_off", gen_relay, 32'h00000000);
    push(B_MAN, 12);
    check("mode_man", mode, fpmc_pkg::MODE_MANUAL);
    check("off_lamp", leds.off, 32'h00000000);
    push(B_START, 12);
    check("eng_run", {engine, leds.eng_run}, 32'h00000003);
    check("run_lamps", {leds.eng_run, leds.eng_stop}, 32'h00000002);
    push(B_TOG, 12);
    check("gen_relay", {mains_relay, gen_relay}, 32'h00000003);
    check("mains_lamps", {leds.mains_on, leds.mains_off}, 32'h00000001);
    check("gen_lamps", {leds.gen_on, leds.gen_off}, 32'h00000002);
    push(B_GOPEN, 12);
    check("gen_open", {gen_relay, leds.gen_off}, 32'h00000001);
    push(B_TOM, 12);
    check("to_mains", {mains_relay, leds.mains_on}, 32'h00000001);
    push(B_MOPEN, 12);
    check("mains_open", mains_relay, 32'h00000001);
    push(B_TOM, 12);
    push(B_STOP, 12);
    check("eng_stop", {engine, leds.eng_stop}, 32'h00000001);
    check("stop_lamp", {leds.eng_run, leds.eng_stop}, 32'h00000001);
    // Dual-use buttons in normal running; a long press acts once.
    failure <= 1'b1;
    horn <= 1'b1;
    clr_ev();
    push(B_INC, 12);
    push(B_DEC, 12);
    push(B_SEL, 40);
    check("fail_reset", {ev_acc.fail_reset, ev_acc.param_up}, 32'h00000002);
    check("alarm_mute", {ev_acc.alarm_mute, ev_acc.param_down}, 32'h00000002);
    check("disp_step", ev_acc.display_step, 32'h00000001);
    check("step_count", n_step, 32'h00000001);
    failure <= 1'b0;
    horn <= 1'b0;
    push(B_TEST, 12);
    check("mode_test", {mode, leds.test}, 32'h00000007);
    check("test_eng", leds.eng_run, 32'h00000001);
    push(B_TOG, 12);
    check("test_gen", gen_relay, 32'h00000000);
    push(B_AUTO, 12);
    check("mode_auto", {mode, leds.auto_m}, 32'h00000005);
    check("test_dark", leds.test, 32'h00000000);
    check("auto_eng", {engine, gen_relay}, 32'h00000003);
    // A long hold outside off mode only runs the lamp check.
    fork
      fpmc_panel_model_i.hold(B_CHK, 70);
      begin
        repeat (20) @(posedge clock_i);
        check("all_lit", all_lit, 32'h00000001);
      end
    join
    repeat (10) @(posedge clock_i);
    check("no_prog", {mode, leds.prog}, 32'h00000004);
    check("restore", {all_lit, leds.auto_m}, 32'h00000001);
    push(B_OFF, 12);
    check("mode_off", {mode, engine, leds.off}, 32'h00000001);
    fork
      fpmc_panel_model_i.hold(B_CHK, 75);
      begin
        repeat (20) @(posedge clock_i);
        check("check_first", {all_lit, mode}, 32'h00000008);
      end
    join
    check("mode_prog", mode, fpmc_pkg::MODE_PROG);
    check("prog_lamp", {leds.prog, leds.off}, 32'h00000002);
    clr_ev();
    push(B_INC, 12);
    push(B_DEC, 12);
    push(B_SEL, 12);
    check("param_up", ev_acc.param_up, 32'h00000001);
    check("param_down", ev_acc.param_down, 32'h00000001);
    check("confirm", ev_acc.param_confirm, 32'h00000001);
    repeat (60) @(posedge clock_i);
    check("still_prog", mode, fpmc_pkg::MODE_PROG);
    repeat (60) @(posedge clock_i);
    check("idle_exit", {mode, leds.prog}, 32'h00000000);
    end_sim();
  end
endmodule // testbench
